// ==== spoc_top.sv ====
// safety pwm output control: one modulated output with fault latches
`timescale 1ns/100ps
`default_nettype none

// restartable lockout timer, done once hold has lasted cyc cycles
module spoc_lockout #(
    parameter int unsigned CYC = spoc_pkg::LOCK_CYC
) (
    input wire logic clk,       // system clock
    input wire logic arst_n,    // async reset, active low
    input wire logic hold,      // condition being timed
    output logic done           // hold has lasted long enough
);
    localparam logic [spoc_pkg::LOCK_W-1:0] LAST =
        spoc_pkg::LOCK_W'(CYC - 1);
    logic [spoc_pkg::LOCK_W-1:0] cnt_r, cnt_nxt;
    logic done_r, done_nxt;

    // restart on every turn-off, saturate at the end
    always_comb begin
        cnt_nxt = cnt_r;
        if (!hold) begin
            cnt_nxt = '0; // RULE_20
        end else if (cnt_r != LAST) begin
            cnt_nxt = cnt_r + 1'b1;
        end
        done_nxt = hold && (cnt_r == LAST);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule // spoc_lockout

// What this block does
// RULE_01: temp fault clears after off and cool
// RULE_02: safety failure sticks until power cycle
// RULE_03: switch recloses after 250 ms, command off
// RULE_04: supply fault clears after off and supply return
// RULE_05: open-loop and closed-loop modes selectable
// RULE_06: open loop drives duty, current monitored
// RULE_07: current range selectable, 10 to 3000 mA
// RULE_08: period 33 to 4000 Hz, or fixed
// RULE_09: stepped dither 33-250 Hz, up to 0.5 A
// RULE_10: current command step is 0.25 mA
// RULE_11: closed loop over maximum latches output off
// RULE_12: latched output stays off 250 ms
// RULE_13: latch reset only with command zero
// RULE_14: instant over-current latches, software clears
// RULE_15: application zeroes signal with power output
// RULE_16: redundant switch held open 250 ms
// RULE_17: open redundant switch blocks all sourcing
// RULE_18: switch feedback to secondary, current to primary
// RULE_19: status bits stay until recovery is complete
// RULE_20: lockout counters restart at each turn-off
module spoc_top #(
    parameter int unsigned LOCK_CYC = spoc_pkg::LOCK_CYC, // 250 ms
    parameter bit FIX_FREQ = 1'b0,     // pin runs at a fixed period
    parameter bit DITHER_EN = 1'b1     // pin supports dither
) (
    input wire logic REF_CLK,           // 100 MHz system clock
    input wire logic ARST_N,            // async reset, active low
    input wire logic [7:0] REG_ADDR,    // register byte address
    input wire logic [31:0] REG_WDATA,  // write data
    input wire logic REG_WR,            // write strobe
    input wire logic REG_RD,            // read strobe
    output logic [31:0] REG_RDATA,      // read data, cycle after strobe
    input wire logic [13:0] CUR_MEAS,   // measured current, 0.25 mA
    input wire logic INST_OC,           // instantaneous over-current
    input wire logic TEMP_FAULT,        // over temperature or open load
    input wire logic SUPPLY_OK,         // supply within range
    input wire logic SAFETY_FAIL,       // safety layer failure
    input wire logic SEC_SW_REQ,        // secondary wants switch closed
    input wire logic SEC_SW_FB,         // redundant switch voltage
    output logic PWM_OUT,               // primary high-side drive
    output logic SAFE_SW_OUT,           // redundant series switch
    output logic SEC_FB_OUT             // switch feedback to secondary
);
    // register file
    logic en_r, en_nxt, auto_r, auto_nxt, clr_r, clr_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [13:0] setpt_r, setpt_nxt;
    logic [14:0] per_r, per_nxt, dth_half_r, dth_half_nxt;
    logic [11:0] fs_r, fs_nxt;
    logic [7:0] dth_amp_r, dth_amp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    // modulation
    logic [6:0] pre_r, pre_nxt;
    logic [14:0] cnt_r, cnt_nxt, duty_r, duty_nxt;
    logic [14:0] dth_cnt_r, dth_cnt_nxt;
    logic dth_ph_r, dth_ph_nxt, pwm_r, pwm_nxt;
    // status and switch
    logic st3_r, st3_nxt, st4_r, st4_nxt, st5_r, st5_nxt;
    logic st6_r, st6_nxt, st8_r, st8_nxt;
    spoc_pkg::spoc_sw_t sw_r, sw_nxt;
    logic safe_r, safe_nxt, fb_r, fb_nxt;
    // shared terms
    logic cmd_off, over_max, drive_ok, tick, per_end, mode_bad;
    logic ovl_done, sw_done;
    logic [14:0] per_eff, dth_eff, tgt_hi, tgt_lo;
    logic [13:0] amp, fs_q;
    logic [8:0] status;

    // command zero means disabled or setpoint zero
    always_comb begin
        cmd_off = !en_r || (setpt_r == 14'h0000); // RULE_13
        fs_q = {fs_r, 2'b00};
        over_max = (mode_r == spoc_pkg::MODE_CLOSED) && (CUR_MEAS > fs_q);
        mode_bad = (mode_r != spoc_pkg::MODE_OPEN
                    && mode_r != spoc_pkg::MODE_CLOSED)
                   || (fs_r < spoc_pkg::FS_MIN_MA)
                   || (fs_r > spoc_pkg::FS_MAX_MA); // RULE_07
        drive_ok = !cmd_off && !st3_r && !st4_r && !st5_r && !st6_r
                   && !st8_r && (sw_r == spoc_pkg::SW_CLOSED); // RULE_17
        status = {st8_r, (sw_r != spoc_pkg::SW_CLOSED), st6_r, st5_r,
                  st4_r, st3_r, 3'b000};
    end

    // period and dither clamped to the legal span
    always_comb begin
        if (FIX_FREQ) begin
            per_eff = spoc_pkg::FIX_PER_US; // RULE_08
        end else if (per_r < spoc_pkg::PER_MIN_US) begin
            per_eff = spoc_pkg::PER_MIN_US;
        end else if (per_r > spoc_pkg::PER_MAX_US) begin
            per_eff = spoc_pkg::PER_MAX_US;
        end else begin
            per_eff = per_r; // RULE_08
        end
        if (dth_half_r < spoc_pkg::DTH_MIN_US) begin
            dth_eff = spoc_pkg::DTH_MIN_US;
        end else if (dth_half_r > spoc_pkg::DTH_MAX_US) begin
            dth_eff = spoc_pkg::DTH_MAX_US;
        end else begin
            dth_eff = dth_half_r; // RULE_09
        end
        amp = 14'({dth_amp_r, 3'b000}); // RULE_09
        if (amp > spoc_pkg::DTH_AMP_MAX || !DITHER_EN) begin
            amp = DITHER_EN ? spoc_pkg::DTH_AMP_MAX : 14'h0000;
        end
        tgt_hi = {1'b0, setpt_r} + {1'b0, amp};
        tgt_lo = (setpt_r > amp) ? {1'b0, setpt_r - amp} : 15'h0000;
    end

    // register writes and one-cycle-late reads
    always_comb begin
        en_nxt = en_r;
        mode_nxt = mode_r;
        auto_nxt = auto_r;
        clr_nxt = 1'b0;
        setpt_nxt = setpt_r;
        per_nxt = per_r;
        fs_nxt = fs_r;
        dth_half_nxt = dth_half_r;
        dth_amp_nxt = dth_amp_r;
        rdata_nxt = 32'h0000_0000;
        if (REG_WR) begin
            case (REG_ADDR)
                spoc_pkg::ADR_CTRL: begin
                    en_nxt = REG_WDATA[spoc_pkg::CTRL_EN];
                    mode_nxt = REG_WDATA[spoc_pkg::CTRL_MODE +: 2]; // RULE_05
                    auto_nxt = REG_WDATA[spoc_pkg::CTRL_AUTO];
                    clr_nxt = REG_WDATA[spoc_pkg::CTRL_CLR]; // RULE_14
                end
                spoc_pkg::ADR_SETPT: setpt_nxt = REG_WDATA[13:0]; // RULE_10
                spoc_pkg::ADR_PER: per_nxt = REG_WDATA[14:0];
                spoc_pkg::ADR_FS: fs_nxt = REG_WDATA[11:0];
                spoc_pkg::ADR_DITH: begin
                    dth_half_nxt = REG_WDATA[14:0];
                    dth_amp_nxt = REG_WDATA[spoc_pkg::DTH_AMP_LSB +: 8];
                end
                default: ;
            endcase
        end
        if (REG_RD) begin
            case (REG_ADDR)
                spoc_pkg::ADR_CTRL:
                    rdata_nxt = {28'h000_0000, auto_r, mode_r, en_r};
                spoc_pkg::ADR_SETPT: rdata_nxt = {18'h0_0000, setpt_r};
                spoc_pkg::ADR_PER: rdata_nxt = {17'h0_0000, per_r};
                spoc_pkg::ADR_FS: rdata_nxt = {20'h0_0000, fs_r};
                spoc_pkg::ADR_DITH:
                    rdata_nxt = {8'h00, dth_amp_r, 1'b0, dth_half_r};
                spoc_pkg::ADR_STAT: // RULE_18
                    rdata_nxt = {2'b00, CUR_MEAS, 6'h00, fb_r, status};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            en_r <= spoc_pkg::EN_RST;
            mode_r <= spoc_pkg::MODE_RST;
            auto_r <= spoc_pkg::AUTO_RST;
            clr_r <= 1'b0;
            setpt_r <= spoc_pkg::SETPT_RST;
            per_r <= spoc_pkg::PER_RST;
            fs_r <= spoc_pkg::FS_RST;
            dth_half_r <= spoc_pkg::DTH_HALF_RST;
            dth_amp_r <= spoc_pkg::DTH_AMP_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            en_r <= en_nxt;
            mode_r <= mode_nxt;
            auto_r <= auto_nxt;
            clr_r <= clr_nxt;
            setpt_r <= setpt_nxt;
            per_r <= per_nxt;
            fs_r <= fs_nxt;
            dth_half_r <= dth_half_nxt;
            dth_amp_r <= dth_amp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // modulator; closed loop nudges duty once per period, which is slow
    // but cannot overshoot into the trip point in one step
    always_comb begin
        tick = (pre_r == spoc_pkg::TICK_LAST);
        per_end = tick && (cnt_r >= per_eff - 15'h0001);
        pre_nxt = tick ? 7'h00 : pre_r + 7'h01;
        cnt_nxt = cnt_r;
        dth_cnt_nxt = dth_cnt_r;
        dth_ph_nxt = dth_ph_r;
        duty_nxt = duty_r;
        if (tick) begin
            cnt_nxt = per_end ? 15'h0000 : cnt_r + 15'h0001;
            if (dth_cnt_r >= dth_eff - 15'h0001) begin
                dth_cnt_nxt = 15'h0000;
                dth_ph_nxt = !dth_ph_r; // RULE_09
            end else begin
                dth_cnt_nxt = dth_cnt_r + 15'h0001;
            end
        end
        if (!drive_ok) begin
            duty_nxt = 15'h0000;
        end else if (mode_r == spoc_pkg::MODE_OPEN) begin
            duty_nxt = ({1'b0, setpt_r} > per_eff) ? per_eff
                       : {1'b0, setpt_r}; // RULE_06
        end else if (per_end) begin
            if ({1'b0, CUR_MEAS} < (dth_ph_r ? tgt_hi : tgt_lo)) begin
                duty_nxt = (duty_r + spoc_pkg::DUTY_STEP > per_eff)
                           ? per_eff
                           : duty_r + spoc_pkg::DUTY_STEP; // RULE_05
            end else begin
                duty_nxt = (duty_r > spoc_pkg::DUTY_STEP)
                           ? duty_r - spoc_pkg::DUTY_STEP : 15'h0000;
            end
        end
        pwm_nxt = drive_ok && !INST_OC && !over_max
                  && (cnt_nxt < duty_nxt); // RULE_17
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pre_r <= 7'h00;
            cnt_r <= 15'h0000;
            duty_r <= 15'h0000;
            dth_cnt_r <= 15'h0000;
            dth_ph_r <= 1'b0;
            pwm_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            cnt_r <= cnt_nxt;
            duty_r <= duty_nxt;
            dth_cnt_r <= dth_cnt_nxt;
            dth_ph_r <= dth_ph_nxt;
            pwm_r <= pwm_nxt;
        end
    end

    // overload lockout runs while latched and commanded off
    spoc_lockout #(.CYC(LOCK_CYC)) u_ovl_lock (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .hold(st4_r && cmd_off), // RULE_12
        .done(ovl_done)
    );

    // redundant switch lockout runs while the switch is open
    spoc_lockout #(.CYC(LOCK_CYC)) u_sw_lock (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .hold(sw_r != spoc_pkg::SW_CLOSED), // RULE_16
        .done(sw_done)
    );

    // fault latches: a set in the clearing cycle always wins
    always_comb begin
        st3_nxt = TEMP_FAULT || (st3_r && !cmd_off); // RULE_01
        st4_nxt = INST_OC || over_max // RULE_11
                  || (st4_r && !(ovl_done && cmd_off
                                 && (auto_r || clr_r))); // RULE_13
        st5_nxt = mode_bad; // RULE_19
        st6_nxt = st6_r || SAFETY_FAIL; // RULE_02
        st8_nxt = !SUPPLY_OK || (st8_r && !cmd_off); // RULE_04
        fb_nxt = SEC_SW_FB; // RULE_18
        sw_nxt = sw_r;
        case (sw_r)
            spoc_pkg::SW_CLOSED: begin
                if (!SEC_SW_REQ || st6_r) begin
                    sw_nxt = spoc_pkg::SW_OPEN_WAIT; // RULE_16
                end
            end
            spoc_pkg::SW_OPEN_WAIT: begin
                if (!SEC_SW_REQ || st6_r) begin
                    sw_nxt = spoc_pkg::SW_OPEN_WAIT;
                end else if (sw_done) begin
                    sw_nxt = spoc_pkg::SW_OPEN_READY; // RULE_03
                end
            end
            spoc_pkg::SW_OPEN_READY: begin
                if (SEC_SW_REQ && cmd_off && !st6_r) begin
                    sw_nxt = spoc_pkg::SW_CLOSED; // RULE_03
                end
            end
            default: sw_nxt = spoc_pkg::SW_OPEN_WAIT;
        endcase
        safe_nxt = (sw_nxt == spoc_pkg::SW_CLOSED);
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st3_r <= 1'b0;
            st4_r <= 1'b0;
            st5_r <= 1'b0;
            st6_r <= 1'b0;
            st8_r <= 1'b0;
            sw_r <= spoc_pkg::SW_OPEN_WAIT;
            safe_r <= 1'b0;
            fb_r <= 1'b0;
        end else begin
            st3_r <= st3_nxt;
            st4_r <= st4_nxt;
            st5_r <= st5_nxt;
            st6_r <= st6_nxt;
            st8_r <= st8_nxt;
            sw_r <= sw_nxt;
            safe_r <= safe_nxt;
            fb_r <= fb_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign PWM_OUT = pwm_r;
    assign SAFE_SW_OUT = safe_r;
    assign SEC_FB_OUT = fb_r;

    // checks on the latches, the switch and the modulator
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    sequence s_trip;
        INST_OC ##1 (st4_r && !PWM_OUT);
    endsequence

    safety_sticky_a: assert property (st6_r |=> st6_r) // RULE_02
        else $error("safety failure bit dropped");
    temp_clear_a: assert property ($fell(st3_r) |-> // RULE_01
        $past(cmd_off) && !$past(TEMP_FAULT))
        else $error("temperature bit cleared too early");
    supply_clear_a: assert property ($fell(st8_r) |-> // RULE_04
        $past(SUPPLY_OK) && $past(cmd_off))
        else $error("supply bit cleared too early");
    inst_trip_a: assert property (INST_OC |-> s_trip) // RULE_14
        else $error("over-current did not latch off");
    loop_trip_a: assert property (over_max |=> st4_r ##1 !PWM_OUT) // RULE_11
        else $error("closed loop trip missed");
    relatch_wait_a: assert property ($fell(st4_r) |-> // RULE_12
        $past(ovl_done) && $past(cmd_off))
        else $error("latch released before lockout");
    switch_block_a: assert property ((sw_r != spoc_pkg::SW_CLOSED)
        |=> !PWM_OUT) // RULE_17
        else $error("sourcing with redundant switch open");
    switch_close_a: assert property ($rose(SAFE_SW_OUT) |-> // RULE_03
        $past(sw_done, 2) && $past(cmd_off))
        else $error("redundant switch closed too early");
    stat_read_a: assert property ((REG_RD && REG_ADDR == spoc_pkg::ADR_STAT)
        |=> REG_RDATA[8:3] == $past(status[8:3])) // RULE_19
        else $error("status read mismatch");
endmodule // spoc_top

`default_nettype wire

// ==== spoc_pkg.sv ====
// constants and types of the safety pwm output control block
package spoc_pkg;
    // clock and lockout timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned LOCK_MS = 250;
    localparam int unsigned LOCK_CYC = LOCK_MS * 1000 * CLK_MHZ;
    localparam int unsigned LOCK_W = 25;
    localparam int unsigned TICK_US = 1;
    localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);
    // modulation period limits in microseconds
    localparam logic [14:0] PER_MIN_US = 15'h00FA;   // 4000 Hz
    localparam logic [14:0] PER_MAX_US = 15'h765F;   // 33 Hz
    localparam logic [14:0] FIX_PER_US = 15'h03E8;   // fixed-rate pins
    // dither half period limits in microseconds
    localparam logic [14:0] DTH_MIN_US = 15'h07D0;   // 250 Hz
    localparam logic [14:0] DTH_MAX_US = 15'h3B2F;   // 33 Hz
    localparam logic [13:0] DTH_AMP_MAX = 14'h07D0;  // 0.5 A in 0.25 mA
    localparam int unsigned DTH_AMP_SHIFT = 3;       // one step is 2 mA
    // full scale current range in mA
    localparam logic [11:0] FS_MIN_MA = 12'h00A;
    localparam logic [11:0] FS_MAX_MA = 12'hBB8;
    localparam logic [14:0] DUTY_STEP = 15'h0004;
    // register byte offsets
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_SETPT = 8'h04;
    localparam logic [7:0] ADR_PER = 8'h08;
    localparam logic [7:0] ADR_FS = 8'h0C;
    localparam logic [7:0] ADR_DITH = 8'h10;
    localparam logic [7:0] ADR_STAT = 8'h14;
    // field positions
    localparam int unsigned CTRL_EN = 0;
    localparam int unsigned CTRL_MODE = 1;
    localparam int unsigned CTRL_AUTO = 3;
    localparam int unsigned CTRL_CLR = 8;
    localparam int unsigned DTH_AMP_LSB = 16;
    localparam int unsigned ST_TEMP = 3;
    localparam int unsigned ST_OVL = 4;
    localparam int unsigned ST_MODE = 5;
    localparam int unsigned ST_SAFE = 6;
    localparam int unsigned ST_SW = 7;
    localparam int unsigned ST_SUP = 8;
    localparam int unsigned ST_FB = 9;
    localparam int unsigned ST_CUR_LSB = 16;
    // reset values
    localparam logic EN_RST = 1'b0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic AUTO_RST = 1'b1;
    localparam logic [13:0] SETPT_RST = 14'h0000;
    localparam logic [14:0] PER_RST = 15'h03E8;
    localparam logic [11:0] FS_RST = 12'hBB8;
    localparam logic [14:0] DTH_HALF_RST = 15'h07D0;
    localparam logic [7:0] DTH_AMP_RST = 8'h00;
    // operating modes
    typedef enum logic [1:0] {
        MODE_OPEN = 2'b00,
        MODE_CLOSED = 2'b01
    } spoc_mode_t;
    // redundant switch states
    typedef enum logic [1:0] {
        SW_OPEN_WAIT = 2'b00,
        SW_OPEN_READY = 2'b01,
        SW_CLOSED = 2'b10
    } spoc_sw_t;
endpackage

// ==== spoc_load.sv ====
// coil load model that sits behind the modulated output
`timescale 1ns/100ps
`default_nettype none

module spoc_load (
    input wire logic clk,          // system clock
    input wire logic arst_n,       // async reset, active low
    input wire logic drive,        // primary high-side drive
    input wire logic sw_closed,    // redundant switch closed
    input wire logic short_req,    // bench asks for a hard short
    input wire logic over_req,     // bench asks for an overload
    output logic [13:0] cur_meas,  // coil current, 0.25 mA steps
    output logic inst_oc,          // over-current comparator
    output logic sw_fb             // redundant switch voltage
);
    logic [13:0] cur_r;

    // coil current lags the drive and only rises with both switches shut, otherwise decays
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_r <= 14'h0000;
        end else if (drive && sw_closed) begin
            cur_r <= (cur_r == 14'h3FFF) ? cur_r : cur_r + 14'h0001;
        end else begin
            cur_r <= (cur_r == 14'h0000) ? cur_r : cur_r - 14'h0001;
        end
    end

    // overload and short are only ever injected on bench command
    assign cur_meas = over_req ? 14'h3FFF : cur_r;
    assign inst_oc = short_req;
    assign sw_fb = sw_closed;
endmodule // spoc_load
`default_nettype wire

// ==== spoc_top_bench.sv ====
// self-checking bench for the safety pwm output control block
`timescale 1ns/100ps
`default_nettype none

module spoc_top_bench;
    localparam int unsigned LK = 50;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic [31:0] rdata;
    logic temp = 1'b0;
    logic sup_ok = 1'b1;
    logic sfail = 1'b0;
    logic sw_req = 1'b0;
    logic short_req = 1'b0;
    logic over_req = 1'b0;
    logic [13:0] cur;
    logic ioc, fb, pwm, sw, sfb;
    logic [31:0] d;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    int hi;

    // 100 MHz clock
    always #5 clk = ~clk;

    spoc_top #(.LOCK_CYC(LK)) uut (
        .REF_CLK(clk), .ARST_N(arst_n), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd_s), .REG_RDATA(rdata),
        .CUR_MEAS(cur), .INST_OC(ioc), .TEMP_FAULT(temp),
        .SUPPLY_OK(sup_ok), .SAFETY_FAIL(sfail), .SEC_SW_REQ(sw_req),
        .SEC_SW_FB(fb), .PWM_OUT(pwm), .SAFE_SW_OUT(sw), .SEC_FB_OUT(sfb));

    spoc_load load (
        .clk(clk), .arst_n(arst_n), .drive(pwm), .sw_closed(sw),
        .short_req(short_req), .over_req(over_req), .cur_meas(cur),
        .inst_oc(ioc), .sw_fb(fb));

    task automatic report_and_stop();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang ends the run through the same report
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fails = fails + 1;
            $display("CHECK FAILED run length expected end seen hang");
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_bit(input string what, input logic exp,
                           input logic got);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one-cycle strobes; read data stand only in the following cycle
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
        @(posedge clk);
    endtask

    task automatic sb(input int b, input logic exp, input string what);
        rreg(spoc_pkg::ADR_STAT, d);
        chk_bit(what, exp, d[b]);
    endtask

    task automatic t_regs();
        sb(spoc_pkg::ST_SW, 1'b1, "switch open at reset");
        chk("fault bits", 32'h0000_0000, d & 32'h0000_0178);
        rreg(spoc_pkg::ADR_CTRL, d);
        chk("ctrl reset", 32'h0000_0008, d);
        rreg(spoc_pkg::ADR_FS, d);
        chk("full scale reset", 32'h0000_0BB8, d);
        rreg(8'h20, d);
        chk("unmapped read", 32'h0000_0000, d);
        wreg(spoc_pkg::ADR_PER, 32'h0000_0010);
        rreg(spoc_pkg::ADR_PER, d);
        chk("period low stored", 32'h0000_0010, d);
        wreg(spoc_pkg::ADR_PER, 32'h0000_7FFF);
        rreg(spoc_pkg::ADR_PER, d);
        chk("period high stored", 32'h0000_7FFF, d);
        wreg(spoc_pkg::ADR_DITH, 32'h00FF_0010);
        rreg(spoc_pkg::ADR_DITH, d);
        chk("dither stored", 32'h00FF_0010, d);
        wreg(spoc_pkg::ADR_SETPT, 32'h0000_3FFF);
        rreg(spoc_pkg::ADR_SETPT, d);
        chk("setpoint width", 32'h0000_3FFF, d);
        wreg(spoc_pkg::ADR_SETPT, 32'h0000_0000);
    endtask

    task automatic t_switch();
        @(posedge clk);
        sw_req <= 1'b1;
        tick(LK + 5);
        chk_bit("switch closes", 1'b1, sw);
        chk_bit("switch feedback", 1'b1, sfb);
        @(posedge clk);
        sw_req <= 1'b0;
        tick(2);
        sw_req <= 1'b1;
        tick(LK - 10);
        chk_bit("switch held open", 1'b0, sw);
        sb(spoc_pkg::ST_SW, 1'b1, "switch open bit");
        tick(20);
        chk_bit("switch recloses", 1'b1, sw);
        // command on: reclose refused and no sourcing allowed
        wreg(spoc_pkg::ADR_SETPT, 32'h0000_0064);
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0009);
        sw_req <= 1'b0;
        tick(2);
        sw_req <= 1'b1;
        hi = 0;
        repeat (LK + 20) begin
            @(posedge clk);
            hi += int'(pwm === 1'b1);
        end
        chk("drive while open", 32'h0000_0000, 32'(hi));
        chk_bit("reclose refused", 1'b0, sw);
        wreg(spoc_pkg::ADR_SETPT, 32'h0000_0000);
        tick(5);
        chk_bit("reclose after off", 1'b1, sw);
    endtask

    task automatic t_open();
        wreg(spoc_pkg::ADR_PER, 32'h0000_0010);
        wreg(spoc_pkg::ADR_SETPT, 32'h0000_007D);
        over_req <= 1'b1;
        tick(100);
        hi = 0;
        repeat (25000) begin
            @(posedge clk);
            hi += int'(pwm === 1'b1);
        end
        chk_bit("half duty", 1'b1, hi >= 12400 && hi <= 12600);
        sb(spoc_pkg::ST_OVL, 1'b0, "no trip open loop");
        chk("current field", 32'h0000_3FFF, 32'(d[29:16]));
        over_req <= 1'b0;
    endtask

    task automatic t_trip();
        short_req <= 1'b1;
        @(posedge clk);
        short_req <= 1'b0;
        #1 chk_bit("trip drive off", 1'b0, pwm);
        tick(LK + 10);
        sb(spoc_pkg::ST_OVL, 1'b1, "latch with command on");
        chk_bit("latched drive off", 1'b0, pwm);
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0008);
        tick(LK - 10);
        sb(spoc_pkg::ST_OVL, 1'b1, "repower lockout");
        tick(20);
        sb(spoc_pkg::ST_OVL, 1'b0, "auto clear");
        // manual clear path with auto clear off
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0001);
        short_req <= 1'b1;
        tick(2);
        short_req <= 1'b0;
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0000);
        tick(LK + 10);
        sb(spoc_pkg::ST_OVL, 1'b1, "waits for software");
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0100);
        tick(2);
        sb(spoc_pkg::ST_OVL, 1'b0, "software clear");
    endtask

    task automatic t_closed();
        wreg(spoc_pkg::ADR_FS, 32'h0000_0005);
        sb(spoc_pkg::ST_MODE, 1'b1, "range too low");
        wreg(spoc_pkg::ADR_FS, 32'h0000_0BB9);
        sb(spoc_pkg::ST_MODE, 1'b1, "range too high");
        wreg(spoc_pkg::ADR_FS, 32'h0000_000A);
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_000C);
        sb(spoc_pkg::ST_MODE, 1'b1, "invalid mode");
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_000B);
        sb(spoc_pkg::ST_MODE, 1'b0, "closed loop valid");
        over_req <= 1'b1;
        tick(3);
        sb(spoc_pkg::ST_OVL, 1'b1, "over maximum trip");
        over_req <= 1'b0;
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0008);
        tick(LK + 10);
        sb(spoc_pkg::ST_OVL, 1'b0, "closed trip cleared");
    endtask

    task automatic t_faults();
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0009);
        temp <= 1'b1;
        tick(3);
        temp <= 1'b0;
        tick(3);
        sb(spoc_pkg::ST_TEMP, 1'b1, "temp held, cmd on");
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0008);
        tick(3);
        sb(spoc_pkg::ST_TEMP, 1'b0, "temp cleared");
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0009);
        sup_ok <= 1'b0;
        tick(3);
        sup_ok <= 1'b1;
        tick(3);
        sb(spoc_pkg::ST_SUP, 1'b1, "supply held, cmd on");
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0008);
        tick(3);
        sb(spoc_pkg::ST_SUP, 1'b0, "supply cleared");
        sfail <= 1'b1;
        tick(3);
        sfail <= 1'b0;
        wreg(spoc_pkg::ADR_CTRL, 32'h0000_0100);
        tick(LK + 10);
        sb(spoc_pkg::ST_SAFE, 1'b1, "safety sticks");
        arst_n <= 1'b0;
        tick(10);
        arst_n <= 1'b1;
        tick(2);
        sb(spoc_pkg::ST_SAFE, 1'b0, "safety after power cycle");
    endtask

    // reset, then each scenario in turn
    initial begin
        tick(10);
        arst_n <= 1'b1;
        tick(1);
        t_regs();
        t_switch();
        t_open();
        t_trip();
        t_closed();
        t_faults();
        report_and_stop();
    end
endmodule // spoc_top_bench
`default_nettype wire
